/* rtl/blink_pkg.sv */
// Constants, types and decode functions for the four-sink blink timer.
// Assumes a single 50 MHz clock; all durations are kept in milliseconds.
package blink_pkg;

  // ----------------------------------------------------------------------
  // Clock and sink count
  // ----------------------------------------------------------------------
  // A clock in kHz equals its number of cycles per millisecond
  localparam int unsigned CLK_FREQ_KHZ = 50_000;
  localparam int unsigned NUM_SINKS    = 4;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_ENABLE   = 6'h10;
  localparam logic [5:0] IDX_ON_TIME  = 6'h11;
  localparam logic [5:0] IDX_OFF_TIME = 6'h12;
  localparam logic [5:0] IDX_STATUS   = 6'h14;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned FIELD_W         = 2;
  localparam int unsigned ON_FIELD_LSB    = 6;
  localparam int unsigned STATUS_DARK_LSB = 4;
  localparam logic [3:0]  ENABLE_RST      = 4'h0;
  localparam logic [1:0]  ON_TIME_RST     = 2'h0;
  localparam logic [7:0]  OFF_TIME_RST    = 8'h00;
  localparam logic [1:0]  OFF_DISABLED    = 2'h0;

  // ----------------------------------------------------------------------
  // Durations in milliseconds
  // ----------------------------------------------------------------------
  localparam int unsigned ON_MS_0  = 200;
  localparam int unsigned ON_MS_1  = 600;
  localparam int unsigned ON_MS_2  = 800;
  localparam int unsigned ON_MS_3  = 1200;
  localparam int unsigned OFF_MS_1 = 600;
  localparam int unsigned OFF_MS_2 = 1200;
  localparam int unsigned OFF_MS_3 = 1800;

  // Phase of one sink, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ON   = 3'b010,
    PH_DARK = 3'b100
  } phase_e;

  // Shared on duration for a field code
  function automatic int unsigned on_ms(input logic [1:0] code);
    unique case (code)
      2'h0:    on_ms = ON_MS_0;
      2'h1:    on_ms = ON_MS_1;
      2'h2:    on_ms = ON_MS_2;
      default: on_ms = ON_MS_3;
    endcase
  endfunction : on_ms

  // Off duration for a field code; zero means no off phase
  function automatic int unsigned off_ms(input logic [1:0] code);
    unique case (code)
      2'h1:    off_ms = OFF_MS_1;
      2'h2:    off_ms = OFF_MS_2;
      2'h3:    off_ms = OFF_MS_3;
      default: off_ms = 0;
    endcase
  endfunction : off_ms

endpackage : blink_pkg

/* rtl/sink_timer_if.sv */
// Bundle between the register block and the per-sink phase timers.
// Assumes every sink timer drives only its own bit of lit and dark.
`timescale 1ns/1ps
interface sink_timer_if;
  logic [3:0] enable;
  logic [1:0] on_time;
  logic [7:0] off_time;
  logic [3:0] lit;
  logic [3:0] dark;

  modport ctrl (output enable, output on_time, output off_time,
                input lit, input dark);
  modport sink (input enable, input on_time, input off_time,
                output lit, output dark);
endinterface : sink_timer_if

/* rtl/sink_blink_phase.sv */
// On/off phase timer for one current sink.
// Assumes enable and timing fields come from registers on the same clock.
`timescale 1ns/1ps
module sink_blink_phase
  import blink_pkg::*;
#(
  parameter int unsigned sink_idx      = 0,
  parameter int unsigned cycles_per_ms = CLK_FREQ_KHZ
) (
  input  wire logic      pclk,
  input  wire logic      presetn,
  sink_timer_if.sink     bus
);

  // Elaboration check: one field per sink, rate within counter range
  if (sink_idx >= NUM_SINKS || cycles_per_ms < 1
      || cycles_per_ms > 1_000_000) begin : g_bad_param
    $error("sink_blink_phase parameter out of range");
  end

  typedef struct packed {
    phase_e      phase;
    logic [31:0] count;
    logic        lit;
    logic        dark;
  } phase_s;

  phase_s      st;
  phase_s      next_st;
  logic        en;
  logic [1:0]  code;
  logic [31:0] on_cyc;
  logic [31:0] off_cyc;

  // Field selection and duration in cycles
  assign en      = bus.enable[sink_idx];
  assign code    = bus.off_time[FIELD_W*sink_idx +: FIELD_W];
  assign on_cyc  = 32'(on_ms(bus.on_time) * cycles_per_ms);
  assign off_cyc = 32'(off_ms(code) * cycles_per_ms);

  // ----------------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    unique case (st.phase)
      PH_IDLE: begin
        next_st.phase = PH_ON;
        next_st.count = 32'h0;
      end
      PH_ON: begin
        if (code == OFF_DISABLED) begin
          next_st.count = 32'h0;
        end else if (st.count + 32'h1 >= on_cyc) begin
          next_st.phase = PH_DARK;
          next_st.count = 32'h0;
        end else begin
          next_st.count = st.count + 32'h1;
        end
      end
      PH_DARK: begin
        if (code == OFF_DISABLED || st.count + 32'h1 >= off_cyc) begin
          next_st.phase = PH_ON;
          next_st.count = 32'h0;
        end else begin
          next_st.count = st.count + 32'h1;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
        next_st.count = 32'h0;
      end
    endcase
    // Disable wins over everything and parks the sink idle, neither lit nor dark
    if (!en) begin
      next_st.phase = PH_IDLE;
      next_st.count = 32'h0;
    end
    next_st.lit  = (next_st.phase == PH_ON);
    next_st.dark = (next_st.phase == PH_DARK);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: PH_IDLE, count: 32'h0, lit: 1'b0, dark: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign bus.lit[sink_idx]  = st.lit;
  assign bus.dark[sink_idx] = st.dark;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_steady_on_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    en && code == OFF_DISABLED |=> st.lit)
    else $error("sink not lit with off phase disabled");

  chk_off_when_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    !en |=> !st.lit && !st.dark)
    else $error("disabled sink still active");

  chk_restart_in_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(en) |=> st.lit && st.count == 32'h0)
    else $error("enable did not restart in on phase");

  chk_on_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.dark) |-> $past(st.count) + 32'h1 >= $past(on_cyc))
    else $error("on phase ended early");

  chk_off_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(st.dark) && st.lit && $past(code) != OFF_DISABLED
      |-> $past(st.count) + 32'h1 >= $past(off_cyc))
    else $error("off phase ended early");

  chk_off_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code == 2'h1 |-> off_cyc == 32'(OFF_MS_1 * cycles_per_ms)) and
    (code == 2'h2 |-> off_cyc == 32'(OFF_MS_2 * cycles_per_ms)) and
    (code == 2'h3 |-> off_cyc == 32'(OFF_MS_3 * cycles_per_ms)))
    else $error("off time decode wrong");

  chk_on_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (bus.on_time == 2'h0 |-> on_cyc == 32'(ON_MS_0 * cycles_per_ms)) and
    (bus.on_time == 2'h3 |-> on_cyc == 32'(ON_MS_3 * cycles_per_ms)))
    else $error("on time decode wrong");

endmodule : sink_blink_phase

/* rtl/sink_blink_off_timer_1to4.sv */
// APB register block and blink timer for current sinks one to four.
// Assumes a 50 MHz pclk, an APB master on the same clock, no pin inputs.
//
// What this block does
// - Off-time fields: sink4 bits 7:6, sink3 5:4, sink2 3:2, sink1 1:0.
// - Off code 00 none, 01 0.6 s, 10 1.2 s, 11 1.8 s.
// - Off code 00 keeps an enabled sink steadily on, no blinking.
// - Nonzero off code: sink on for on-time, then off for that time.
// - Enable 1 with off code 00 drives the sink continuously on.
// - Sinks enabled by one write start their sequences together.
// - Shared on-time field codes select 0.2, 0.6, 0.8, 1.2 seconds.
// - Enable register holds sink N at bit N-1; 1 on, 0 off.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module sink_blink_off_timer_1to4
  import blink_pkg::*;
#(
  parameter int unsigned cycles_per_ms = CLK_FREQ_KHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  sink_on
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (cycles_per_ms < 1 || cycles_per_ms > 1_000_000) begin : g_bad_rate
    $error("cycles_per_ms out of range");
  end

  typedef struct packed {
    logic [3:0]  enable;
    logic [1:0]  on_time;
    logic [7:0]  off_time;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_s;

  regs_s       st;
  regs_s       next_st;
  logic        setup;
  logic        commit;
  logic [31:0] rd_word;
  logic        mapped;

  sink_timer_if sif ();

  // Byte address match for a register index
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // APB phase decode and read mux
  // ----------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign commit = psel && penable && st.pready;
  assign mapped = reg_hit(paddr, IDX_ENABLE) || reg_hit(paddr, IDX_ON_TIME)
               || reg_hit(paddr, IDX_OFF_TIME) || reg_hit(paddr, IDX_STATUS);

  // Read data; unused bits read as zero
  always_comb begin
    rd_word = 32'h0;
    if (reg_hit(paddr, IDX_ENABLE)) begin
      rd_word[3:0] = st.enable;
    end
    if (reg_hit(paddr, IDX_ON_TIME)) begin
      rd_word[ON_FIELD_LSB +: FIELD_W] = st.on_time;
    end
    if (reg_hit(paddr, IDX_OFF_TIME)) begin
      rd_word[7:0] = st.off_time;
    end
    if (reg_hit(paddr, IDX_STATUS)) begin
      rd_word[3:0] = sif.lit;
      rd_word[STATUS_DARK_LSB +: NUM_SINKS] = sif.dark;
    end
  end

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.pready = setup;  // One wait-free access cycle after setup
    if (setup) begin
      next_st.prdata  = pwrite ? 32'h0 : rd_word;
      next_st.pslverr = !mapped;
    end
    if (commit && pwrite && mapped && pstrb[0]) begin
      if (reg_hit(paddr, IDX_ENABLE)) begin
        // Every bit lands on the same edge so sequences start together
        next_st.enable = pwdata[3:0];
      end
      if (reg_hit(paddr, IDX_ON_TIME)) begin
        next_st.on_time = pwdata[ON_FIELD_LSB +: FIELD_W];
      end
      if (reg_hit(paddr, IDX_OFF_TIME)) begin
        next_st.off_time = pwdata[7:0];
      end
    end
    if (commit) begin
      next_st.prdata  = 32'h0;
      next_st.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{enable: ENABLE_RST, on_time: ON_TIME_RST,
              off_time: OFF_TIME_RST, prdata: 32'h0,
              pready: 1'b0, pslverr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Sink timers
  // ----------------------------------------------------------------------
  assign sif.enable   = st.enable;
  assign sif.on_time  = st.on_time;
  assign sif.off_time = st.off_time;

  // One phase timer per sink
  for (genvar i = 0; i < NUM_SINKS; i++) begin : g_sink
    sink_blink_phase #(
      .sink_idx      (i),
      .cycles_per_ms (cycles_per_ms)
    ) i_sink_blink_phase (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (sif)
    );
  end

  // Outputs straight from flip-flops
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign sink_on = sif.lit;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_off_field_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && pstrb[0] && reg_hit(paddr, IDX_OFF_TIME)
      |=> st.off_time == $past(pwdata[7:0]))
    else $error("off time register not written");

  chk_enable_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && pstrb[0] && reg_hit(paddr, IDX_ENABLE)
      |=> st.enable == $past(pwdata[3:0]))
    else $error("enable register not written");

  chk_on_field_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && pstrb[0] && reg_hit(paddr, IDX_ON_TIME)
      |=> st.on_time == $past(pwdata[7:6]))
    else $error("on time field not written");

  chk_sync_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.enable[0]) && $rose(st.enable[3])
      |=> sink_on[0] && sink_on[3] && $past(!sink_on[0] && !sink_on[3]))
    else $error("sinks enabled together did not start together");

  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready || (psel && !penable))
    else $error("access phase not answered in one cycle");

  chk_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr)
    else $error("unmapped address not flagged");

  chk_ready_in_access: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("pready outside an access phase");

  chk_strobe_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && !pstrb[0] |=> $stable(st.enable)
      && $stable(st.on_time) && $stable(st.off_time))
    else $error("write without lane strobe changed a register");

  chk_error_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> prdata == 32'h0)
    else $error("unmapped read returned data");

  chk_status_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && reg_hit(paddr, IDX_STATUS)
      |=> prdata == {24'h0, $past(sif.dark), $past(sif.lit)})
    else $error("status read does not show sink phases");

  chk_sync_all_lit: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.enable == 4'hF && $past(st.enable) == 4'h0 |=> sink_on == 4'hF)
    else $error("sinks enabled together not lit together");

endmodule : sink_blink_off_timer_1to4

/* dv/tb_sink_blink_off_timer_1to4.sv */
// Self-checking bench for the four-sink blink timer with its APB registers.
// Assumes the design answers APB with its own pready; no partner model.
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("mismatch %0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module tb_sink_blink_off_timer_1to4
  import blink_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and timing tables
  // ----------------------------------------------------------------------
  localparam int unsigned CPM = 2;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sink_on;
  int          check_count;
  int          miscompares;
  int unsigned on_tab [4] = '{ON_MS_0, ON_MS_1, ON_MS_2, ON_MS_3};
  int unsigned off_tab [4] = '{0, OFF_MS_1, OFF_MS_2, OFF_MS_3};

  sink_blink_off_timer_1to4 #(.cycles_per_ms(CPM))
    i_sink_blink_off_timer_1to4 (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .sink_on (sink_on)
  );

  // Clock of 20 ns period
  always #10 pclk = ~pclk;

  // ----------------------------------------------------------------------
  // Bus and closing tasks
  // ----------------------------------------------------------------------
  // One APB transfer; pready, prdata and pslverr are taken at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Access lasts until pready is seen high at an edge; watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values, field layout, refused accesses, enable bit mapping
  task automatic test_regs();
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 8'h40, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h0);
    apb(1'b0, 8'h48, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h0);
    `CHK(sink_on, 4'h0);
    apb(1'b1, 8'h48, 32'hE4, 4'hF, rd, err);
    apb(1'b0, 8'h48, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'hE4);
    apb(1'b1, 8'h44, 32'hFF, 4'hF, rd, err);
    apb(1'b0, 8'h44, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'hC0);
    apb(1'b0, 8'h4C, 32'h0, 4'h0, rd, err);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    apb(1'b1, 8'h40, 32'hF, 4'h0, rd, err);
    apb(1'b0, 8'h40, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h0);
    `CHK(err, 1'b0);
    `CHK(sink_on, 4'h0);
    apb(1'b1, 8'h48, 32'h0, 4'hF, rd, err);
    apb(1'b1, 8'h40, 32'h4, 4'hF, rd, err);
    @(posedge pclk);
    #1;
    `CHK(sink_on, 4'h4);
    apb(1'b0, 8'h50, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h4);
    apb(1'b1, 8'h40, 32'h0, 4'hF, rd, err);
    $display("test_regs done");
  endtask : test_regs

  // All sinks enabled in one write; every cycle compared with the model
  task automatic test_blink(input logic [1:0] code);
    logic [31:0] rd;
    logic        err;
    logic [3:0]  exp;
    int unsigned on_c;
    int unsigned off_c;
    int unsigned len;
    on_c = on_tab[code] * CPM;
    len = 2 * on_c + off_tab[3] * CPM + 20;
    apb(1'b1, 8'h44, {24'h0, code, 6'h00}, 4'hF, rd, err);
    // Sink1 code 0, sink2 code 1, sink3 code 2, sink4 code 3
    apb(1'b1, 8'h48, 32'hE4, 4'hF, rd, err);
    apb(1'b1, 8'h40, 32'hF, 4'hF, rd, err);
    for (int unsigned t = 0; t < len; t++) begin
      @(posedge pclk);
      #1;
      for (int i = 0; i < 4; i++) begin
        off_c = off_tab[i] * CPM;
        exp[i] = (off_c == 0) || ((t % (on_c + off_c)) < on_c);
      end
      `CHK(sink_on, exp);
    end
    // Status shows each sink lit or in its off phase as the model has it
    for (int i = 0; i < 4; i++) begin
      off_c = off_tab[i] * CPM;
      exp[i] = (off_c == 0) || ((len % (on_c + off_c)) < on_c);
    end
    apb(1'b0, 8'h50, 32'h0, 4'h0, rd, err);
    `CHK(rd, {24'h0, ~exp, exp});
    apb(1'b1, 8'h40, 32'h0, 4'hF, rd, err);
    @(posedge pclk);
    #1;
    `CHK(sink_on, 4'h0);
    $display("test_blink done, on code %0d", code);
  endtask : test_blink

  // Reset in mid-run clears the registers and parks every sink
  task automatic test_reset();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 8'h40, 32'hF, 4'hF, rd, err);
    @(posedge pclk);
    #1;
    `CHK(sink_on, 4'hF);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    `CHK(sink_on, 4'h0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h40, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h0);
    apb(1'b0, 8'h48, 32'h0, 4'h0, rd, err);
    `CHK(rd, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  // Reset held four cycles, then the scenarios in turn
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    paddr       = 8'h00;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    check_count = 0;
    miscompares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    for (int c = 0; c < 4; c++) begin
      test_blink(c[1:0]);
    end
    test_reset();
    test_done();
  end

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    $display("watchdog expired");
    test_done();
  end

endmodule : tb_sink_blink_off_timer_1to4
